/* File: core/dwd_params.svh */
/*
 Constants for the dual watchdog: counter width, counter reset value,
 window limits, oscillator rates and response encodings.
 Assumes inclusion by bare name from the package and the modules.
*/
`ifndef DWD_PARAMS_SVH
`define DWD_PARAMS_SVH

`define DWD_CNT_W        14
`define DWD_CNT_MAX      14'h3FFF
`define DWD_WIN_FULL_HI  14'h3FFF
`define DWD_WIN_FULL_LO  14'h0000
`define DWD_SYS_CLK_KHZ  100000
`define DWD_IND_OSC_KHZ  15
`define DWD_IND_DIV      (`DWD_SYS_CLK_KHZ / `DWD_IND_OSC_KHZ)
`define DWD_RESP_RESET   2'h0
`define DWD_RESP_NMI     2'h1
`define DWD_RESP_IRQ     2'h2

`endif

/* File: core/dwd_pkg.sv */
/*
 Types shared by the dual watchdog modules.
 Assumes dwd_params.svh is on the include path.
*/
`include "dwd_params.svh"

package dwd_pkg;
   typedef logic [`DWD_CNT_W-1:0] dwd_cnt_t;
   typedef logic [1:0]            dwd_resp_t;
   typedef enum logic [1:0] {
      DWD_IDLE,
      DWD_RUN,
      DWD_FAULT
   } dwd_state_e;
endpackage

/* File: core/dwd_counter.sv */
/*
 One 14-bit supervising down-counter with refresh window and response select.
 Assumes tick_in is a one-cycle pulse on clock_in, refresh_in a one-cycle pulse.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dwd_params.svh"

module dwd_counter
   import dwd_pkg::*;
(
   // Clock and reset
   input  wire logic      clock_in,
   input  wire logic      srst_in,
   // Configuration
   input  wire logic      enable_in,
   input  wire logic      auto_start_in,
   input  wire dwd_cnt_t  reload_in,
   input  wire dwd_cnt_t  win_hi_in,
   input  wire dwd_cnt_t  win_lo_in,
   input  wire dwd_resp_t resp_in,
   // Events
   input  wire logic      tick_in,
   input  wire logic      refresh_in,
   // Outputs
   output dwd_cnt_t       count_out,
   output logic           running_out,
   output logic           reset_req_out,
   output logic           nmi_req_out,
   output logic           irq_req_out,
   output logic           refresh_err_out,
   output logic           underflow_out
);

   dwd_state_e state_q, state_d;
   dwd_cnt_t   cnt_q, cnt_d;
   logic       rst_q, rst_d, nmi_q, nmi_d, irq_q, irq_d;
   logic       rerr_q, rerr_d, uf_q, uf_d;
   logic       run_q, run_d;
   logic       in_win, fault;

   // Window holds when counter lies between low and high limits inclusive
   assign in_win = (cnt_q <= win_hi_in) && (cnt_q >= win_lo_in);

   // Next-state, counting and response logic
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      rst_d   = 1'b0;
      nmi_d   = 1'b0;
      irq_d   = 1'b0;
      rerr_d  = 1'b0;
      uf_d    = 1'b0;
      fault   = 1'b0;
      case (state_q)
         DWD_IDLE: begin
            // Starts on auto-start after reset or on first refresh
            if (enable_in && (auto_start_in || refresh_in)) begin
               state_d = DWD_RUN;
               cnt_d   = reload_in;
            end
         end
         DWD_RUN: begin
            if (!enable_in) begin
               state_d = DWD_IDLE;
            end else if (refresh_in && !in_win) begin
               rerr_d = 1'b1;
               fault  = 1'b1;
            end else if (refresh_in) begin
               cnt_d = reload_in;
            end else if (tick_in) begin
               if (cnt_q == '0) begin
                  uf_d  = 1'b1;
                  fault = 1'b1;
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end
            if (fault) begin
               // One-cycle request on the selected response line
               rst_d   = (resp_in == `DWD_RESP_RESET);
               nmi_d   = (resp_in == `DWD_RESP_NMI);
               irq_d   = (resp_in == `DWD_RESP_IRQ);
               state_d = DWD_FAULT;
               cnt_d   = reload_in;
            end
         end
         DWD_FAULT: begin
            // Auto restart after fault, else wait for refresh
            if (enable_in && (auto_start_in || refresh_in)) begin
               state_d = DWD_RUN;
            end else if (!enable_in) begin
               state_d = DWD_IDLE;
            end
         end
         default: begin
            state_d = DWD_IDLE;
         end
      endcase
      // Running flag follows the next state, so the output comes from a flop
      run_d = (state_d == DWD_RUN);
   end

   // Registers only
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         state_q <= DWD_IDLE;
         cnt_q   <= `DWD_CNT_MAX;
         rst_q   <= 1'b0;
         nmi_q   <= 1'b0;
         irq_q   <= 1'b0;
         rerr_q  <= 1'b0;
         uf_q    <= 1'b0;
         run_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         rst_q   <= rst_d;
         nmi_q   <= nmi_d;
         irq_q   <= irq_d;
         rerr_q  <= rerr_d;
         uf_q    <= uf_d;
         run_q   <= run_d;
      end
   end

   assign count_out       = cnt_q;
   assign running_out     = run_q;
   assign reset_req_out   = rst_q;
   assign nmi_req_out     = nmi_q;
   assign irq_req_out     = irq_q;
   assign refresh_err_out = rerr_q;
   assign underflow_out   = uf_q;

endmodule
`default_nettype wire

/* File: core/dwd_top.sv */
/*
 Dual watchdog: a system-clock watchdog and an independent-clock watchdog.
 Each watchdog is one dwd_counter; this file adds the synchroniser for the
 independent oscillator pin and merges the two response sets onto shared
 request lines.
 Assumes software control arrives as plain ports synchronous to clock_in, and the
 independent oscillator arrives as a pin sampled into the clock_in domain.
 Assumes the oscillator runs far slower than clock_in, so that each high and
 low phase of the pin spans at least two clock_in cycles.
 Assumes the reset and interrupt controllers fed by the request lines take
 one-cycle pulses; the status pulses tell which watchdog raised a request.
 Response code 3 raises no request line, only the status pulses.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dwd_params.svh"

module dwd_top
   import dwd_pkg::*;
(
   // Clock and reset
   input  wire logic      clock_in,
   input  wire logic      srst_in,
   // Independent oscillator pin, nominally 15 kHz
   input  wire logic      ind_osc_in,
   // System-clock watchdog configuration
   input  wire logic      sys_enable_in,
   input  wire logic      sys_auto_start_in,
   input  wire dwd_cnt_t  sys_reload_in,
   input  wire dwd_cnt_t  sys_win_hi_in,
   input  wire dwd_cnt_t  sys_win_lo_in,
   input  wire dwd_resp_t sys_resp_in,
   input  wire logic      sys_tick_in,
   input  wire logic      sys_refresh_in,
   // Independent-clock watchdog configuration
   input  wire logic      ind_enable_in,
   input  wire logic      ind_auto_start_in,
   input  wire dwd_cnt_t  ind_reload_in,
   input  wire dwd_cnt_t  ind_win_hi_in,
   input  wire dwd_cnt_t  ind_win_lo_in,
   input  wire dwd_resp_t ind_resp_in,
   input  wire logic      ind_refresh_in,
   // System-clock watchdog status
   output dwd_cnt_t       sys_count_out,
   output logic           sys_running_out,
   output logic           sys_refresh_err_out,
   output logic           sys_underflow_out,
   // Independent-clock watchdog status
   output dwd_cnt_t       ind_count_out,
   output logic           ind_running_out,
   output logic           ind_refresh_err_out,
   output logic           ind_underflow_out,
   // Merged fault responses
   output logic           chip_reset_req_out,
   output logic           nmi_req_out,
   output logic           irq_req_out
);

   // Oscillator synchroniser stages and the edge history flop;
   // two stages before the detector, one more for its history
   logic osc_s1_q;
   logic osc_s1_d;
   logic osc_s2_q;
   logic osc_s2_d;
   logic osc_s3_q;
   logic osc_s3_d;

   // One-cycle count pulse for the independent watchdog
   logic ind_tick;

   // Response pulses of the system-clock watchdog
   logic s_rst;
   logic s_nmi;
   logic s_irq;

   // Response pulses of the independent-clock watchdog
   logic i_rst;
   logic i_nmi;
   logic i_irq;

   // Merged response registers and their next values
   logic rst_q;
   logic rst_d;
   logic nmi_q;
   logic nmi_d;
   logic irq_q;
   logic irq_d;

   // Synchroniser next values
   always_comb begin
      // Stage one may go metastable; only stage two reads it
      osc_s1_d = ind_osc_in;
      osc_s2_d = osc_s1_q;
      osc_s3_d = osc_s2_q;  // One cycle of history for edge detect
   end

   // Synchroniser registers. Reset to high, so a pin that is already high
   // at reset release is not taken for a rising edge and a spurious count
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         osc_s1_q <= 1'b1;
         osc_s2_q <= 1'b1;
         osc_s3_q <= 1'b1;
      end else begin
         osc_s1_q <= osc_s1_d;
         osc_s2_q <= osc_s2_d;
         osc_s3_q <= osc_s3_d;
      end
   end

   // Counts only on oscillator rising edges, independent of sys_tick_in.
   // Limitation: the edge is seen through clock_in, so the independent
   // watchdog counts only while clock_in runs; a stopped clock_in has to
   // be caught outside this block
   assign ind_tick = osc_s2_q && !osc_s3_q;

   // Watchdog counting on system-clock ticks
   dwd_counter u_sys (
      // Shared clock and reset
      .clock_in        (clock_in),
      .srst_in         (srst_in),
      // Configuration
      .enable_in       (sys_enable_in),
      .auto_start_in   (sys_auto_start_in),
      .reload_in       (sys_reload_in),
      .win_hi_in       (sys_win_hi_in),
      .win_lo_in       (sys_win_lo_in),
      .resp_in         (sys_resp_in),
      // Count and refresh events
      .tick_in         (sys_tick_in),
      .refresh_in      (sys_refresh_in),
      // Status
      .count_out       (sys_count_out),
      .running_out     (sys_running_out),
      // Response pulses to the merge
      .reset_req_out   (s_rst),
      .nmi_req_out     (s_nmi),
      .irq_req_out     (s_irq),
      .refresh_err_out (sys_refresh_err_out),
      .underflow_out   (sys_underflow_out)
   );

   // Watchdog counting on the dedicated oscillator, same responses
   dwd_counter u_ind (
      // Shared clock and reset
      .clock_in        (clock_in),
      .srst_in         (srst_in),
      // Configuration
      .enable_in       (ind_enable_in),
      .auto_start_in   (ind_auto_start_in),
      .reload_in       (ind_reload_in),
      .win_hi_in       (ind_win_hi_in),
      .win_lo_in       (ind_win_lo_in),
      .resp_in         (ind_resp_in),
      // Count and refresh events
      .tick_in         (ind_tick),
      .refresh_in      (ind_refresh_in),
      // Status
      .count_out       (ind_count_out),
      .running_out     (ind_running_out),
      // Response pulses to the merge
      .reset_req_out   (i_rst),
      .nmi_req_out     (i_nmi),
      .irq_req_out     (i_irq),
      .refresh_err_out (ind_refresh_err_out),
      .underflow_out   (ind_underflow_out)
   );

   // One request line rises when either watchdog asks for it;
   // used for all three lines so they cannot drift apart
   function automatic logic dwd_merge(input logic sys_req, input logic ind_req);
      dwd_merge = sys_req | ind_req;
   endfunction

   // Merge both response sets into one pulse each. Both watchdogs may
   // fault in one cycle; the merge then gives one pulse, not two.
   // A watchdog set to code 3 adds nothing here
   always_comb begin
      // Chip reset request
      rst_d = dwd_merge(s_rst, i_rst);
      // Non-maskable request
      nmi_d = dwd_merge(s_nmi, i_nmi);
      // Maskable request
      irq_d = dwd_merge(s_irq, i_irq);
   end

   // Registered so merged outputs come from flip-flops; the pulse
   // leaves one cycle after the watchdog's own status pulse
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         rst_q <= 1'b0;
         nmi_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         // Pulses pass through, one cycle late
         rst_q <= rst_d;
         nmi_q <= nmi_d;
         irq_q <= irq_d;
      end
   end

   // Chip reset request straight from its flop
   assign chip_reset_req_out = rst_q;
   // Non-maskable request straight from its flop
   assign nmi_req_out        = nmi_q;
   // Maskable request straight from its flop
   assign irq_req_out        = irq_q;

endmodule
`default_nettype wire

/* File: verification/dwd_asserts.sv */
/*
 Checker for dwd_top: count, window, underflow and response timing.
 Assumes it is bound to dwd_top and sees one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dwd_params.svh"
module dwd_chk
   import dwd_pkg::*;
(
   // Watched inputs
   input wire logic      clock_in,
   input wire logic      srst_in,
   input wire logic      sys_enable_in,
   input wire logic      sys_auto_start_in,
   input wire dwd_cnt_t  sys_reload_in,
   input wire dwd_cnt_t  sys_win_hi_in,
   input wire dwd_cnt_t  sys_win_lo_in,
   input wire dwd_resp_t sys_resp_in,
   input wire logic      sys_tick_in,
   input wire logic      sys_refresh_in,
   input wire logic      ind_enable_in,
   input wire logic      ind_refresh_in,
   input wire dwd_cnt_t  ind_win_hi_in,
   input wire dwd_cnt_t  ind_win_lo_in,
   // Watched outputs
   input wire dwd_cnt_t  sys_count_out,
   input wire logic      sys_running_out,
   input wire logic      sys_refresh_err_out,
   input wire logic      sys_underflow_out,
   input wire logic      ind_running_out,
   input wire dwd_cnt_t  ind_count_out,
   input wire logic      ind_refresh_err_out,
   input wire logic      chip_reset_req_out,
   input wire logic      nmi_req_out,
   input wire logic      irq_req_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (srst_in);
   // Requests taken in the run state; refresh wins over tick
   wire logic s_ref = sys_running_out && sys_enable_in && sys_refresh_in;
   wire logic s_in  = sys_count_out >= sys_win_lo_in && sys_count_out <= sys_win_hi_in;
   wire logic s_tk  = sys_running_out && sys_enable_in && sys_tick_in && !sys_refresh_in;
   wire logic i_ref = ind_running_out && ind_enable_in && ind_refresh_in;
   wire logic i_in  = ind_count_out >= ind_win_lo_in && ind_count_out <= ind_win_hi_in;
   a_reset_values: assert property ($fell(srst_in) |-> sys_count_out == `DWD_CNT_MAX && !sys_running_out)
      else $error("reset values wrong");
   a_tick_decrement: assert property (s_tk && sys_count_out != 0 |=> sys_count_out == $past(sys_count_out) - 1)
      else $error("count did not decrement");
   a_tick_underflow: assert property (s_tk && sys_count_out == 0 |=> sys_underflow_out)
      else $error("no underflow at zero");
   a_reset_resp: assert property (sys_underflow_out && sys_resp_in == `DWD_RESP_RESET |=> chip_reset_req_out)
      else $error("no chip reset request");
   a_nmi_resp: assert property (sys_underflow_out && sys_resp_in == `DWD_RESP_NMI |=> nmi_req_out && !irq_req_out)
      else $error("no nmi request");
   a_irq_resp: assert property (sys_underflow_out && sys_resp_in == `DWD_RESP_IRQ |=> irq_req_out && !nmi_req_out)
      else $error("no irq request");
   a_window_error: assert property (s_ref && !s_in |=> sys_refresh_err_out ##1 !sys_refresh_err_out)
      else $error("refresh error missing");
   a_window_reload: assert property (s_ref && s_in |=> !sys_refresh_err_out && sys_count_out == $past(sys_reload_in))
      else $error("refresh did not reload");
   a_ind_window: assert property (i_ref && !i_in |=> ind_refresh_err_out)
      else $error("independent refresh error missing");
   a_auto_restart: assert property (sys_underflow_out && sys_auto_start_in && sys_enable_in |=> sys_running_out)
      else $error("no restart after fault");
   // Main scenarios reached
   c_underflow: cover property (sys_underflow_out);
   c_sys_err: cover property (sys_refresh_err_out);
   c_ind_err: cover property (ind_refresh_err_out);
   c_no_resp: cover property (sys_underflow_out && sys_resp_in == 2'h3);
endmodule
`default_nettype wire

/* File: verification/dwd_top_tb.sv */
/*
 Self-checking bench for dwd_top with directed scenarios.
 Assumes the design files and dwd_asserts.sv are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dwd_params.svh"
module dwd_top_tb
   import dwd_pkg::*;
;
   // Stimulus, all given a value at time zero
   logic      clock_in, srst_in = 1, ind_osc_in = 0, seen_irq = 0, seen_ind_uf = 0;
   logic      sys_enable_in = 0, sys_auto_start_in = 0, sys_tick_in = 0, sys_refresh_in = 0;
   logic      ind_enable_in = 0, ind_auto_start_in = 0, ind_refresh_in = 0;
   dwd_cnt_t  sys_reload_in = 0, sys_win_hi_in = `DWD_WIN_FULL_HI, sys_win_lo_in = 0;
   dwd_cnt_t  ind_reload_in = 0, ind_win_hi_in = `DWD_WIN_FULL_HI, ind_win_lo_in = 0;
   dwd_resp_t sys_resp_in = 0, ind_resp_in = 0;
   // Observed outputs
   dwd_cnt_t  sys_count_out, ind_count_out;
   logic      sys_running_out, sys_refresh_err_out, sys_underflow_out, ind_running_out;
   logic      ind_refresh_err_out, ind_underflow_out, chip_reset_req_out, nmi_req_out, irq_req_out;
   int        failures = 0, n_compared = 0;
   dwd_top dut (.*);
   initial begin
      clock_in = 0;
      forever #5 clock_in = ~clock_in;
   end
   // Sticky flags, since these pulses last one cycle
   always @(posedge clock_in) if (irq_req_out) seen_irq <= 1'b1;
   always @(posedge clock_in) if (ind_underflow_out) seen_ind_uf <= 1'b1;
   task automatic step(int n = 1);
      repeat (n) begin @(posedge clock_in); #1; end
   endtask
   task automatic chk(string nm, logic [13:0] seen, logic [13:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic t_underflow;
      sys_reload_in = 14'h0002; sys_auto_start_in = 1; sys_enable_in = 1;
      step();
      chk("sys_running", sys_running_out, 1);
      for (int r = 0; r < 3; r++) begin
         sys_resp_in = 2'(r); sys_tick_in = 1;
         step(2);
         chk("sys_count", sys_count_out, 0);
         step();
         sys_tick_in = 0;
         chk("sys_underflow", sys_underflow_out, 1);
         chk("sys_count", sys_count_out, 14'h0002);
         step();
         chk("chip_reset", chip_reset_req_out, r == 0);
         chk("nmi", nmi_req_out, r == 1);
         chk("irq", irq_req_out, r == 2);
         chk("sys_running", sys_running_out, 1);
      end
      $display("underflow test done");
   endtask
   task automatic t_window;
      sys_win_lo_in = 14'h0001; sys_win_hi_in = 14'h0001; sys_resp_in = `DWD_RESP_RESET; sys_refresh_in = 1;
      step();
      sys_refresh_in = 0;
      chk("sys_err", sys_refresh_err_out, 1);
      step();
      chk("chip_reset", chip_reset_req_out, 1);
      sys_tick_in = 1;
      step();
      sys_tick_in = 0; sys_refresh_in = 1;
      step();
      sys_refresh_in = 0;
      chk("sys_err", sys_refresh_err_out, 0);
      chk("sys_count", sys_count_out, 14'h0002);
      step();
      chk("chip_reset", chip_reset_req_out, 0);
      $display("window test done");
   endtask
   task automatic t_ind;
      ind_reload_in = 14'h0001; ind_resp_in = `DWD_RESP_IRQ; ind_auto_start_in = 1; ind_enable_in = 1; seen_irq = 0;
      seen_ind_uf = 0;
      step();
      chk("ind_count", ind_count_out, 14'h0001);
      for (int p = 0; p < 2; p++) begin
         ind_osc_in = 1;
         step(6);
         ind_osc_in = 0;
         step(6);
         chk("ind_count", ind_count_out, 14'(p));
      end
      chk("ind_irq", seen_irq, 1);
      chk("ind_underflow", seen_ind_uf, 1);
      ind_win_lo_in = 14'h0005; ind_win_hi_in = 14'h0005; ind_refresh_in = 1;
      step();
      ind_refresh_in = 0;
      chk("ind_err", ind_refresh_err_out, 1);
      ind_enable_in = 0;
      step(3);
      chk("ind_running", ind_running_out, 0);
      $display("independent test done");
   endtask
   task automatic t_restart;
      // Mid-run reset, then start by refresh alone and response code 3
      srst_in = 1; sys_auto_start_in = 0; sys_resp_in = 2'h3;
      sys_win_lo_in = `DWD_WIN_FULL_LO; sys_win_hi_in = `DWD_WIN_FULL_HI;
      step();
      srst_in = 0;
      chk("sys_count", sys_count_out, `DWD_CNT_MAX);
      step();
      chk("sys_running", sys_running_out, 0);
      sys_refresh_in = 1;
      step();
      chk("sys_running", sys_running_out, 1);
      chk("sys_count", sys_count_out, 14'h0002);
      sys_tick_in = 1;
      step();
      sys_refresh_in = 0;
      chk("sys_count", sys_count_out, 14'h0002);
      step(3);
      sys_tick_in = 0;
      chk("sys_underflow", sys_underflow_out, 1);
      step();
      chk("chip_reset", chip_reset_req_out, 0);
      chk("nmi", nmi_req_out, 0);
      chk("irq", irq_req_out, 0);
      chk("sys_running", sys_running_out, 0);
      sys_refresh_in = 1;
      step();
      sys_refresh_in = 0; sys_enable_in = 0;
      chk("sys_running", sys_running_out, 1);
      step();
      chk("sys_running", sys_running_out, 0);
      $display("restart test done");
   endtask
   initial begin
      step(2);
      srst_in = 0;
      chk("sys_count", sys_count_out, `DWD_CNT_MAX);
      chk("sys_running", sys_running_out, 0);
      $display("reset test done");
      t_underflow();
      t_window();
      t_ind();
      t_restart();
      conclude();
   end
   // Whole run is about 60 cycles
   initial begin
      #50000;
      failures++;
      conclude();
   end
endmodule
bind dwd_top dwd_chk u_chk (.*);
`default_nettype wire
